// >>> asu_baud.sv
// Bit rate generator: sixteen-times oversampling strobe.
// Assumes the clock pin is already synchronous to clock.
`timescale 1ns/1ns
`default_nettype none

module asu_baud (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Configuration
  input wire logic ext_clock,
  input wire logic [1:0] prescale,
  input wire logic [7:0] divisor,
  // External clock pin
  input wire logic serial_clock_pin,
  // Oversampling strobe
  output logic tick16
);
  import asu_pkg::*;

  logic [4:0] pre_q, next_pre;
  logic [7:0] cnt_q, next_cnt;
  logic pin_q, next_pin;
  logic next_tick;
  logic pre_tick;
  logic src_tick;

  always_comb begin
    next_pre = pre_q + 5'h01;
    next_pin = serial_clock_pin;
    case (prescale)
      PRE_DIV8: pre_tick = (pre_q[2:0] == PRE8_LAST);
      PRE_DIV32: pre_tick = (pre_q == PRE32_LAST);
      default: pre_tick = 1'b1;
    endcase
    src_tick = ext_clock ? (serial_clock_pin && !pin_q) : pre_tick;
    next_cnt = cnt_q;
    next_tick = 1'b0;
    if (src_tick) begin
      if (cnt_q >= divisor) begin
        next_cnt = 8'h00;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pre_q <= 5'h00;
      cnt_q <= 8'h00;
      pin_q <= 1'b0;
      tick16 <= 1'b0;
    end else begin
      pre_q <= next_pre;
      cnt_q <= next_cnt;
      pin_q <= next_pin;
      tick16 <= next_tick;
    end
  end

endmodule

`default_nettype wire

// >>> asu_parity.sv
// Parity of the character bits in use.
// Assumes unused upper bits may hold anything.
`timescale 1ns/1ns
`default_nettype none

module asu_parity (
  // Character
  input wire logic [8:0] data,
  input wire logic [1:0] char_len,
  // Exclusive-or of the used bits
  output logic odd_ones
);
  import asu_pkg::*;

  always_comb begin
    odd_ones = ^data[6:0];
    if (char_len != LEN_7) begin
      odd_ones = odd_ones ^ data[7];
    end
    if (char_len != LEN_7 && char_len != LEN_8) begin
      odd_ones = odd_ones ^ data[8];
    end
  end

endmodule

`default_nettype wire

// >>> asu_peer.sv
// Remote serial peer: sends frames, captures frames, drives CTS.
// Assumes frames are handed LSB first with the start bit in bit 0.
`timescale 1ns/1ns
`default_nettype none

module asu_peer (
  // Clock
  input wire logic clock,
  // Serial lines
  input wire logic line_in,
  output var logic line_out,
  output var logic cts_n
);
  initial begin
    line_out = 1'b1;
    cts_n = 1'b1;
  end

  task automatic send_frame(input logic [15:0] f, input int n, input int bl);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      line_out <= f[i];
      repeat (bl - 1) @(posedge clock);
    end
    @(posedge clock);
    line_out <= 1'b1;
  endtask

  // Mid-bit capture after a falling edge
  task automatic get_frame(input int n, input int bl, output logic [15:0] f);
    int t;
    f = '0;
    t = 0;
    while (line_in !== 1'b0 && t < 3000) begin
      @(posedge clock);
      t++;
    end
    repeat (bl / 2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      f[i] = line_in;
      if (i < n - 1) repeat (bl) @(posedge clock);
    end
  endtask

  task automatic set_cts(input logic v);
    @(posedge clock);
    cts_n <= v;
  endtask
endmodule

`default_nettype wire

// >>> asu_pkg.sv
// Shared constants and types of the asynchronous serial channel.
// Assumes a single 250 MHz clock and a 32-bit APB register port.
`default_nettype none

package asu_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_TXB = 8'h0c;
  localparam logic [7:0] OFS_RXB = 8'h10;

  // Values after reset
  localparam logic [31:0] MODE_RESET = 32'h0000_0011;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // Control register bit positions
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_TX_EMPTY = 1;
  localparam int CTRL_RX_EN = 2;
  localparam int CTRL_RX_FULL = 3;

  // Receive buffer status bit positions
  localparam int RXB_OVERRUN = 12;
  localparam int RXB_FRAMING = 13;
  localparam int RXB_PARITY = 14;
  localparam int RXB_ERR_SUM = 15;

  // Character length and prescaler codes
  localparam logic [1:0] LEN_7 = 2'h0;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] PRE_DIV8 = 2'h1;
  localparam logic [1:0] PRE_DIV32 = 2'h2;

  // Cycle counts
  localparam logic [2:0] PRE8_LAST = 3'h7;
  localparam logic [4:0] PRE32_LAST = 5'h1f;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] RX_SPAN = 4'hc;

  typedef struct packed {
    logic open_drain;
    logic tx_irq_done;
    logic [1:0] prescale;
    logic stop_two;
    logic sleep;
    logic parity_en;
    logic parity_even;
    logic flow_disable;
    logic ext_clock;
    logic rts_select;
    logic [1:0] char_len;
  } asu_mode_type;

  typedef struct packed {
    logic err_sum;
    logic parity_err;
    logic framing;
    logic overrun;
    logic [8:0] data;
  } asu_rx_type;

  typedef enum logic [0:0] {TX_IDLE, TX_SEND} asu_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asu_rx_state_type;

endpackage

`default_nettype wire

// >>> asu_uart.sv
// Asynchronous serial channel with APB registers.
// Assumes serial pins are synchronous to clock; interrupt lines go to a controller.
`timescale 1ns/1ns
`default_nettype none

module asu_uart (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  output logic serial_tx_out,
  output logic serial_tx_oe_n,
  input wire logic serial_rx_in,
  input wire logic serial_clock_pin,
  input wire logic cts_in,
  output logic rts_out,
  output logic rts_oe_n,
  // Pin roles
  output logic flow_pin_is_port,
  output logic clock_pin_is_port,
  // Interrupt requests
  output logic tx_irq_req,
  output logic rx_irq_req
);
  import asu_pkg::*;

  asu_mode_type mode_q, next_mode;
  logic [7:0] div_q, next_div;
  logic te_q, next_te, re_q, next_re;
  logic [8:0] txb_q, next_txb;
  logic tx_full_q, next_tx_full;
  asu_rx_type rxb_q, next_rxb;
  logic rx_full_q, next_rx_full;
  logic [31:0] next_prdata;
  logic next_rx_irq;

  asu_tx_state_type tx_state_q, next_tx_state;
  logic [12:0] tx_sh_q, next_tx_sh;
  logic [3:0] tx_left_q, next_tx_left;
  logic [3:0] tx_sub_q, next_tx_sub;
  logic tx_line_q, next_tx_line;
  logic next_tx_irq;

  asu_rx_state_type rx_state_q, next_rx_state;
  logic [11:0] rx_sh_q, next_rx_sh;
  logic [3:0] rx_left_q, next_rx_left;
  logic [3:0] rx_sub_q, next_rx_sub;

  logic tick16, tx_load, tx_fin, rx_end, rx_accept, cts_ok;
  logic wr, rd, setup, hit, rxb_read;
  logic [3:0] nbits, tx_total, rx_total;
  logic [12:0] tx_frame;
  logic [11:0] rx_fr;
  logic [8:0] rx_data;
  logic tx_xr, tx_par, rx_xr, rx_frame_err, rx_par_err, rx_msb;

  asu_baud u_baud (
    .clock(clock),
    .srst(srst),
    .ext_clock(mode_q.ext_clock),
    .prescale(mode_q.prescale),
    .divisor(div_q),
    .serial_clock_pin(serial_clock_pin),
    .tick16(tick16)
  );

  asu_parity u_tx_par (
    .data(txb_q),
    .char_len(mode_q.char_len),
    .odd_ones(tx_xr)
  );

  asu_parity u_rx_par (
    .data(rx_data),
    .char_len(mode_q.char_len),
    .odd_ones(rx_xr)
  );

  // Bus decode; zero wait states
  assign setup = psel && !penable;
  assign pready = psel && penable;
  assign wr = pready && pwrite;
  assign rd = pready && !pwrite;
  assign hit = (paddr == OFS_MODE) || (paddr == OFS_DIV) || (paddr == OFS_CTRL)
    || (paddr == OFS_TXB) || (paddr == OFS_RXB);
  assign pslverr = pready && !hit;
  assign rxb_read = rd && (paddr == OFS_RXB);

  // flow pin role and RTS drive
  assign flow_pin_is_port = mode_q.flow_disable;
  assign rts_oe_n = mode_q.flow_disable || !mode_q.rts_select;
  assign rts_out = !(re_q && !rx_full_q);
  assign clock_pin_is_port = !mode_q.ext_clock;
  assign serial_tx_out = tx_line_q;
  assign serial_tx_oe_n = mode_q.open_drain && tx_line_q;
  assign cts_ok = mode_q.flow_disable || mode_q.rts_select || !cts_in;

  // Frame geometry
  always_comb begin
    case (mode_q.char_len)
      LEN_7: nbits = 4'h7;
      LEN_8: nbits = 4'h8;
      default: nbits = 4'h9;
    endcase
    tx_total = 4'h2 + nbits + {3'h0, mode_q.parity_en} + {3'h0, mode_q.stop_two};
    rx_total = tx_total - 4'h1;
  end

  always_comb begin
    tx_par = tx_xr ^ !mode_q.parity_even;
    tx_frame = 13'h1fff;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nbits)) begin
        tx_frame[i + 1] = txb_q[i];
      end
    end
    if (mode_q.parity_en) begin
      tx_frame[nbits + 4'h1] = tx_par;
    end
  end

  // Received frame unpack
  always_comb begin
    rx_fr = {serial_rx_in, rx_sh_q[11:1]} >> (RX_SPAN - rx_total);
    rx_data = rx_fr[8:0];
    for (int i = 0; i < 9; i++) begin
      if (i >= int'(nbits)) begin
        rx_data[i] = 1'b0;
      end
    end
    rx_msb = rx_fr[nbits - 4'h1];
    // every stop bit must be high
    rx_frame_err = !rx_fr[nbits + {3'h0, mode_q.parity_en}];
    if (mode_q.stop_two && !rx_fr[nbits + {3'h0, mode_q.parity_en} + 4'h1]) begin
      rx_frame_err = 1'b1;
    end
    rx_par_err = mode_q.parity_en && (rx_xr ^ rx_fr[nbits] ^ !mode_q.parity_even);
    rx_accept = rx_end && !(mode_q.sleep && !rx_msb);
  end

  // Transmitter
  always_comb begin
    next_tx_state = tx_state_q;
    next_tx_sh = tx_sh_q;
    next_tx_left = tx_left_q;
    next_tx_sub = tx_sub_q;
    tx_load = 1'b0;
    tx_fin = 1'b0;
    case (tx_state_q)
      TX_IDLE: begin
        if (te_q && tx_full_q && cts_ok) begin
          tx_load = 1'b1;
          next_tx_sh = tx_frame;
          next_tx_left = tx_total;
          next_tx_sub = 4'h0;
          next_tx_state = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tick16) begin
          next_tx_sub = tx_sub_q + 4'h1;
          if (tx_sub_q == SUB_LAST) begin
            next_tx_sh = {1'b1, tx_sh_q[12:1]};
            next_tx_left = tx_left_q - 4'h1;
            if (tx_left_q == 4'h1) begin
              tx_fin = 1'b1;
              next_tx_state = TX_IDLE;
            end
          end
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
    next_tx_line = (next_tx_state == TX_SEND) ? next_tx_sh[0] : 1'b1;
    next_tx_irq = mode_q.tx_irq_done ? tx_fin : tx_load;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_state_q <= TX_IDLE;
      tx_sh_q <= 13'h1fff;
      tx_left_q <= 4'h0;
      tx_sub_q <= 4'h0;
      tx_line_q <= 1'b1;
      tx_irq_req <= 1'b0;
    end else begin
      tx_state_q <= next_tx_state;
      tx_sh_q <= next_tx_sh;
      tx_left_q <= next_tx_left;
      tx_sub_q <= next_tx_sub;
      tx_line_q <= next_tx_line;
      tx_irq_req <= next_tx_irq;
    end
  end

  // Receiver
  always_comb begin
    next_rx_state = rx_state_q;
    next_rx_sh = rx_sh_q;
    next_rx_left = rx_left_q;
    next_rx_sub = rx_sub_q;
    rx_end = 1'b0;
    case (rx_state_q)
      RX_IDLE: begin
        if (re_q && !serial_rx_in && tick16) begin
          next_rx_sub = 4'h0;
          next_rx_state = RX_START;
        end
      end
      RX_START: begin
        if (tick16) begin
          next_rx_sub = rx_sub_q + 4'h1;
          if (rx_sub_q == SUB_MID) begin
            next_rx_sub = 4'h0;
            next_rx_left = rx_total;
            next_rx_state = serial_rx_in ? RX_IDLE : RX_BITS;
          end
        end
      end
      RX_BITS: begin
        if (tick16) begin
          next_rx_sub = rx_sub_q + 4'h1;
          if (rx_sub_q == SUB_LAST) begin
            next_rx_sh = {serial_rx_in, rx_sh_q[11:1]};
            next_rx_left = rx_left_q - 4'h1;
            if (rx_left_q == 4'h1) begin
              rx_end = 1'b1;
              next_rx_state = RX_IDLE;
            end
          end
        end
      end
      default: next_rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_state_q <= RX_IDLE;
      rx_sh_q <= 12'h000;
      rx_left_q <= 4'h0;
      rx_sub_q <= 4'h0;
    end else begin
      rx_state_q <= next_rx_state;
      rx_sh_q <= next_rx_sh;
      rx_left_q <= next_rx_left;
      rx_sub_q <= next_rx_sub;
    end
  end

  // Registers
  always_comb begin
    next_mode = mode_q;
    next_div = div_q;
    next_te = te_q;
    next_re = re_q;
    next_txb = txb_q;
    next_tx_full = tx_full_q && !tx_load;
    next_rxb = rxb_q;
    next_rx_full = rx_full_q;
    next_rx_irq = 1'b0;
    next_prdata = prdata;
    if (wr) begin
      case (paddr)
        OFS_MODE: next_mode = asu_mode_type'(pwdata[12:0]);
        OFS_DIV: next_div = pwdata[7:0];
        OFS_CTRL: begin
          next_te = pwdata[CTRL_TX_EN];
          next_re = pwdata[CTRL_RX_EN];
        end
        OFS_TXB: begin
          next_txb = pwdata[8:0];
          next_tx_full = 1'b1;
        end
        default: next_div = div_q;
      endcase
    end
    if (rxb_read) begin
      next_rx_full = 1'b0;
      next_rxb.overrun = 1'b0;
      next_rxb.framing = 1'b0;
      next_rxb.parity_err = 1'b0;
      next_rxb.err_sum = 1'b0;
    end
    // New character wins over the read clear
    if (rx_accept) begin
      next_rxb.data = rx_data;
      next_rxb.overrun = rx_full_q && !rxb_read;
      next_rxb.framing = rx_frame_err;
      next_rxb.parity_err = rx_par_err;
      next_rxb.err_sum = next_rxb.overrun || rx_frame_err || rx_par_err;
      next_rx_full = 1'b1;
      next_rx_irq = !next_rxb.overrun;
    end
    if (setup && !pwrite) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        OFS_MODE: next_prdata[12:0] = mode_q;
        OFS_DIV: next_prdata[7:0] = div_q;
        OFS_CTRL: begin
          next_prdata[CTRL_TX_EN] = te_q;
          next_prdata[CTRL_TX_EMPTY] = !tx_full_q;
          next_prdata[CTRL_RX_EN] = re_q;
          next_prdata[CTRL_RX_FULL] = rx_full_q;
        end
        OFS_RXB: begin
          next_prdata[8:0] = rxb_q.data;
          next_prdata[RXB_OVERRUN] = rxb_q.overrun;
          next_prdata[RXB_FRAMING] = rxb_q.framing;
          next_prdata[RXB_PARITY] = rxb_q.parity_err;
          next_prdata[RXB_ERR_SUM] = rxb_q.err_sum;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mode_q <= asu_mode_type'(MODE_RESET[12:0]);
      div_q <= DIV_RESET;
      te_q <= 1'b0;
      re_q <= 1'b0;
      txb_q <= 9'h000;
      tx_full_q <= 1'b0;
      rxb_q <= '0;
      rx_full_q <= 1'b0;
      rx_irq_req <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      mode_q <= next_mode;
      div_q <= next_div;
      te_q <= next_te;
      re_q <= next_re;
      txb_q <= next_txb;
      tx_full_q <= next_tx_full;
      rxb_q <= next_rxb;
      rx_full_q <= next_rx_full;
      rx_irq_req <= next_rx_irq;
      prdata <= next_prdata;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  tx_start_gate_a: assert property (
    tx_state_q == TX_IDLE && !(te_q && tx_full_q && cts_ok) |=> tx_state_q == TX_IDLE)
    else $error("transmit started without its conditions");

  idle_line_a: assert property (
    tx_state_q == TX_IDLE && $past(tx_state_q) == TX_IDLE |-> serial_tx_out)
    else $error("serial output not high while idle");

  load_irq_a: assert property (
    tx_load && !mode_q.tx_irq_done && !(wr && paddr == OFS_TXB)
      |=> tx_irq_req && !tx_full_q)
    else $error("no transmit interrupt on buffer load");

  done_irq_a: assert property (
    tx_irq_req && $past(mode_q.tx_irq_done)
      |-> $past(tx_state_q) == TX_SEND && tx_state_q == TX_IDLE)
    else $error("completion interrupt before shifting ended");

  rx_enable_a: assert property (
    rx_state_q == RX_IDLE && !re_q |=> rx_state_q == RX_IDLE)
    else $error("reception began while disabled");

  overrun_a: assert property (
    rx_accept && rx_full_q && !rxb_read |=> !rx_irq_req && rxb_q.overrun && rxb_q.err_sum)
    else $error("overrun not flagged or interrupt raised");

  rx_fill_a: assert property (
    rx_irq_req |-> rx_full_q && $past(rx_accept))
    else $error("receive interrupt without buffer fill");

  sleep_drop_a: assert property (
    rx_end && mode_q.sleep && !rx_msb && !rxb_read |=> $stable(rxb_q) && !rx_irq_req)
    else $error("sleep mode kept an MSB zero character");

  tick_space_a: assert property (
    tick16 && div_q != 8'h00 |=> !tick16)
    else $error("oversampling strobe too fast");

  tx_frame_c: cover property (tx_fin);
  overrun_c: cover property (rx_accept && rx_full_q);
  frame_err_c: cover property (rx_accept && rx_frame_err);
  parity_err_c: cover property (rx_accept && rx_par_err);

endmodule

`default_nettype wire

// >>> tb.sv
// Testbench of the serial channel: APB tasks and frame scenarios.
// Assumes asu_peer on the serial side; 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %0t: got %h want %h", $time, g, e); end end

module tb;
  import asu_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic serial_tx_out;
  logic serial_tx_oe_n;
  logic rx_line;
  logic cts_n;
  logic rts_out;
  logic rts_oe_n;
  logic flow_pin_is_port;
  logic clock_pin_is_port;
  logic tx_irq_req;
  logic rx_irq_req;
  logic tx_wire;
  logic [1:0] ext_cnt = 2'h0;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int n_checks = 0;
  int tx_irqs = 0;
  int rx_irqs = 0;
  int cyc = 0;
  int bl = 16;
  int k;
  int mid;

  initial forever #2 clock = ~clock;

  // Open-drain line floats up to idle
  assign tx_wire = serial_tx_oe_n ? 1'b1 : serial_tx_out;

  asu_uart i_dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_tx_out(serial_tx_out),
    .serial_tx_oe_n(serial_tx_oe_n), .serial_rx_in(rx_line),
    .serial_clock_pin(ext_cnt[1]), .cts_in(cts_n), .rts_out(rts_out),
    .rts_oe_n(rts_oe_n), .flow_pin_is_port(flow_pin_is_port),
    .clock_pin_is_port(clock_pin_is_port), .tx_irq_req(tx_irq_req),
    .rx_irq_req(rx_irq_req));

  asu_peer i_peer (.clock(clock), .line_in(tx_wire), .line_out(rx_line),
    .cts_n(cts_n));

  always @(posedge clock) begin
    ext_cnt <= ext_cnt + 2'h1;
    if (tx_irq_req === 1'b1) tx_irqs <= tx_irqs + 1;
    if (rx_irq_req === 1'b1) rx_irqs <= rx_irqs + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && t < 20) begin
      @(posedge clock);
      t++;
    end
    `CHK(pready, 1'b1)
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the written state settle before callers look at outputs
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  function automatic logic [15:0] mk(input logic [8:0] d, input int nb, par, ev);
    logic [15:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i + 1] = d[i];
    if (par != 0) f[nb + 1] = ^(d & 9'((1 << nb) - 1)) ^ (ev == 0);
    return f;
  endfunction

  task automatic tx_chk(input logic [8:0] d, input int nb, par, ev, ns);
    logic [15:0] f;
    int n;
    n = 1 + nb + par + ns;
    i_peer.get_frame(n, bl, f);
    `CHK(f, mk(d, nb, par, ev) & ~(16'hffff << n))
    mid = tx_irqs;
    repeat (bl) @(posedge clock);
  endtask

  task automatic rx_send(input logic [8:0] d, input int nb, par, ev, ns,
      input logic [15:0] flip);
    i_peer.send_frame(mk(d, nb, par, ev) ^ flip, 1 + nb + par + ns, 16);
    repeat (4) @(posedge clock);
  endtask

  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    `CHK(tx_wire, 1'b1)
    `CHK(flow_pin_is_port, 1'b1)
    `CHK(clock_pin_is_port, 1'b1)
    rdc(OFS_MODE, MODE_RESET);
    rdc(OFS_CTRL, 32'h0000_0002);
    rdc(OFS_DIV, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(err, 1'b1)
    // Transmit formats and interrupt causes
    wr(OFS_CTRL, 32'h0000_0001);
    k = tx_irqs;
    wr(OFS_TXB, 32'h0000_00a5);
    tx_chk(9'h0a5, 8, 0, 0, 1);
    `CHK(mid, k + 1)
    wr(OFS_MODE, 32'h0000_0972);
    k = tx_irqs;
    wr(OFS_TXB, 32'h0000_013c);
    tx_chk(9'h13c, 9, 1, 1, 2);
    `CHK(mid, k)
    `CHK(tx_irqs, k + 1)
    wr(OFS_MODE, 32'h0000_0050);
    wr(OFS_TXB, 32'h0000_005a);
    tx_chk(9'h05a, 7, 1, 0, 1);
    // CTS holds the transmitter back
    wr(OFS_MODE, 32'h0000_0001);
    `CHK(flow_pin_is_port, 1'b0)
    `CHK(rts_oe_n, 1'b1)
    wr(OFS_TXB, 32'h0000_0033);
    repeat (40) @(posedge clock);
    `CHK(tx_wire, 1'b1)
    i_peer.set_cts(1'b0);
    tx_chk(9'h033, 8, 0, 0, 1);
    i_peer.set_cts(1'b1);
    // Receive, RTS, overrun
    wr(OFS_MODE, 32'h0000_0004);
    k = rx_irqs;
    rx_send(9'h05a, 7, 0, 0, 1, 16'h0000);
    `CHK(rx_irqs, k)
    wr(OFS_CTRL, 32'h0000_0005);
    `CHK(rts_oe_n, 1'b0)
    `CHK(rts_out, 1'b0)
    rx_send(9'h05a, 7, 0, 0, 1, 16'h0000);
    `CHK(rx_irqs, k + 1)
    `CHK(rts_out, 1'b1)
    rdc(OFS_CTRL, 32'h0000_000f);
    rdc(OFS_RXB, 32'h0000_005a);
    rdc(OFS_CTRL, 32'h0000_0007);
    rx_send(9'h011, 7, 0, 0, 1, 16'h0000);
    rx_send(9'h022, 7, 0, 0, 1, 16'h0000);
    `CHK(rx_irqs, k + 2)
    rdc(OFS_RXB, 32'h0000_9022);
    // Framing and parity errors
    wr(OFS_MODE, 32'h0000_0111);
    rx_send(9'h0a5, 8, 0, 0, 2, 16'h0200);
    rdc(OFS_RXB, 32'h0000_a0a5);
    wr(OFS_MODE, 32'h0000_0051);
    rx_send(9'h03c, 8, 1, 1, 1, 16'h0000);
    rdc(OFS_RXB, 32'h0000_c03c);
    // Sleep drops characters with a clear top bit
    wr(OFS_MODE, 32'h0000_0091);
    k = rx_irqs;
    rx_send(9'h012, 8, 0, 0, 1, 16'h0000);
    `CHK(rx_irqs, k)
    rx_send(9'h092, 8, 0, 0, 1, 16'h0000);
    `CHK(rx_irqs, k + 1)
    rdc(OFS_RXB, 32'h0000_0092);
    // Prescaler and divisor, then external clock with open drain
    wr(OFS_DIV, 32'h0000_00ff);
    rdc(OFS_DIV, 32'h0000_00ff);
    wr(OFS_DIV, 32'h0000_0001);
    wr(OFS_MODE, 32'h0000_0211);
    bl = 256;
    wr(OFS_TXB, 32'h0000_00c3);
    tx_chk(9'h0c3, 8, 0, 0, 1);
    wr(OFS_DIV, 32'h0000_0000);
    wr(OFS_MODE, 32'h0000_0410);
    bl = 512;
    wr(OFS_TXB, 32'h0000_005a);
    tx_chk(9'h05a, 7, 0, 0, 1);
    wr(OFS_MODE, 32'h0000_1019);
    `CHK(clock_pin_is_port, 1'b0)
    `CHK(serial_tx_oe_n, 1'b1)
    bl = 64;
    wr(OFS_TXB, 32'h0000_005a);
    tx_chk(9'h05a, 8, 0, 0, 1);
    complete_run();
  end
endmodule

`default_nettype wire
